// [msb_cmd_gate.sv]
`timescale 1ns/1ns
module msb_cmd_gate
	import msb_pkg::*;
(
	// commanded bits
	input wire logic [MSB_CMD_W-1:0] cmd,
	input wire logic brake_fitted,
	input wire logic motor_allow,
	// gated drive and fault
	output logic fwd_drive,
	output logic rev_drive,
	output logic brake_drive,
	output logic conflict
);
	// both directions at once never reaches a contactor
	always_comb begin
		conflict = cmd[MSB_CMD_FWD] & cmd[MSB_CMD_REV]; // RL10
		fwd_drive = cmd[MSB_CMD_FWD] & ~conflict & motor_allow; // RL12
		rev_drive = cmd[MSB_CMD_REV] & ~conflict & motor_allow; // RL12
		// brake follows its own bit and brake_fitted only; no link to the motor drive
		brake_drive = cmd[MSB_CMD_BRAKE] & brake_fitted; // RL3 RL4
	end
endmodule

// [msb_evt_flags.sv]
`timescale 1ns/1ns
module msb_evt_flags
	import msb_pkg::*;
#(
	parameter int W = 5
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// events and read-clear strobe
	input wire logic [W-1:0] set,
	input wire logic clr_all,
	// sticky flags
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] flags;
	} msb_evt_state_t;
	msb_evt_state_t st_reg, st_next;

	// set wins over clear so an event in the read cycle is not lost
	always_comb begin
		st_next = st_reg;
		st_next.flags = (clr_all ? '0 : st_reg.flags) | set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign flags = st_reg.flags;
endmodule

// [msb_pkg.sv]
// Overview of operation
// RL1 - address assignment works while fully wired
// RL2 - addressing cable inserted isolates from network
// RL3 - brake bit drives output only if fitted
// RL4 - brake switched independently, no motor interlock
// RL5 - master program coordinates motor and brake safely
// RL6 - ready bit: 1 ready/automatic, 0 not ready/error
// RL7 - manual mode keeps ready low until automatic
// RL8 - protection trip keeps ready low until reclosed
// RL9 - coil, welded contacts, driver fault clear ready
// RL10 - forward plus reverse together is a fault
// RL11 - bit layout follows motor starter slave profile
// RL12 - out0 forward, out1 reverse, out2 brake, out3 unused
// RL13 - input bit1 contactor on, bits 2-3 mirror spares
package msb_pkg;
	localparam int MSB_AW = 8;
	localparam int MSB_DW = 32;
	// register byte offsets
	localparam logic [7:0] MSB_OFS_CMD = 8'h00;
	localparam logic [7:0] MSB_OFS_STATUS = 8'h04;
	localparam logic [7:0] MSB_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] MSB_OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] MSB_OFS_CONFIG = 8'h10;
	localparam logic [7:0] MSB_OFS_SLV_ADDR = 8'h14;
	// command word: output bits of the starter profile
	localparam int MSB_CMD_FWD = 0;
	localparam int MSB_CMD_REV = 1;
	localparam int MSB_CMD_BRAKE = 2;
	localparam int MSB_CMD_W = 3;
	// status word: input bits of the starter profile, then extras
	localparam int MSB_ST_READY = 0;
	localparam int MSB_ST_RUNNING = 1;
	localparam int MSB_ST_SPARE1 = 2;
	localparam int MSB_ST_SPARE2 = 3;
	localparam int MSB_ST_ADDR_MODE = 4;
	localparam int MSB_ST_CONFLICT = 5;
	localparam int MSB_CFG_BRAKE_FITTED = 0;
	// interrupt event bits
	localparam int MSB_EV_READY_LOST = 0;
	localparam int MSB_EV_READY_BACK = 1;
	localparam int MSB_EV_CONFLICT = 2;
	localparam int MSB_EV_ADDR_MODE = 3;
	localparam int MSB_EV_ADDR_SET = 4;
	localparam int MSB_EV_W = 5;
	localparam int MSB_SADDR_W = 5;
	// reset values, bus response codes and channel states
	localparam logic [2:0] MSB_CMD_RST = 3'h0;
	localparam logic [4:0] MSB_MASK_RST = 5'h00;
	localparam logic [4:0] MSB_SADDR_RST = 5'h00;
	localparam logic MSB_BRAKE_FITTED_RST = 1'b0;
	localparam logic [1:0] MSB_RESP_OKAY = 2'h0;
	localparam logic [1:0] MSB_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {MSB_WS_IDLE = 2'b01, MSB_WS_RESP = 2'b10} msb_wst_t;
	typedef enum logic [1:0] {MSB_RS_IDLE = 2'b01, MSB_RS_DATA = 2'b10} msb_rst_t;
endpackage

// [msb_plant.sv]
`timescale 1ns/1ns
module msb_plant
	import msb_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// contactor coil drive
	input wire logic forward_run_out,
	input wire logic reverse_run_out,
	// auxiliary contact feedback
	output logic contactor_on
);
	// the auxiliary contact lags the coil by one cycle, so nothing may assume instant feedback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			contactor_on <= 1'b0;
		end else begin
			contactor_on <= forward_run_out | reverse_run_out;
		end
	end
endmodule

// [msb_top.sv]
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module msb_top
	import msb_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [MSB_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [MSB_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [MSB_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [MSB_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// field feedback
	input wire logic contactor_on,
	input wire logic manual_mode,
	input wire logic protection_tripped,
	input wire logic coil_defect,
	input wire logic contacts_welded,
	input wire logic driver_defect,
	input wire logic spare_field_input_one,
	input wire logic spare_field_input_two,
	// addressing socket and tool
	input wire logic addr_cable_in,
	input wire logic tool_addr_valid,
	input wire logic [MSB_SADDR_W-1:0] tool_addr,
	// contactor and brake drive
	output logic forward_run_out,
	output logic reverse_run_out,
	output logic brake_command_output,
	// network attachment and interrupt
	output logic net_connected,
	output logic irq
);
	typedef struct packed {
		msb_wst_t wst;
		msb_rst_t rst;
		logic aw_have;
		logic [MSB_AW-1:0] aw_addr;
		logic w_have;
		logic [MSB_DW-1:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [MSB_DW-1:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
		logic [MSB_CMD_W-1:0] cmd;
		logic brake_fitted;
		logic [MSB_EV_W-1:0] irq_mask;
		logic [MSB_SADDR_W-1:0] slave_addr;
		logic ready;
		logic running;
		logic spare1;
		logic spare2;
		logic addr_mode;
		logic conflict;
		logic fwd_out;
		logic rev_out;
		logic brake_out;
		logic net_conn;
		logic irq;
		logic ev_armed;
	} msb_top_state_t;

	msb_top_state_t st_reg, st_next;
	logic fwd_drive, rev_drive, brake_drive, conflict;
	logic [MSB_EV_W-1:0] ev_set, flags;
	logic ev_clr;
	logic aw_fire, w_fire, ar_fire, wr_go;
	logic [MSB_AW-1:0] wr_addr;
	logic [MSB_DW-1:0] wr_data;
	logic wr_lane0, ready_now, motor_allow;

	////////////////////////////////////////////////////////////////////////
	// command gating and sticky event flags
	// local mode and a tripped breaker take the contactors away from the bus
	assign motor_allow = ~manual_mode & ~protection_tripped;

	msb_cmd_gate u_gate (
		.cmd(st_reg.cmd),
		.brake_fitted(st_reg.brake_fitted),
		.motor_allow(motor_allow),
		.fwd_drive(fwd_drive),
		.rev_drive(rev_drive),
		.brake_drive(brake_drive),
		.conflict(conflict)
	);

	msb_evt_flags #(
		.W(MSB_EV_W)
	) u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(ev_set),
		.clr_all(ev_clr),
		.flags(flags)
	);

	////////////////////////////////////////////////////////////////////////
	// readiness: every not-ready cause is a level, so ready returns by itself
	assign ready_now = ~manual_mode // RL7
		& ~protection_tripped // RL8
		& ~(coil_defect | contacts_welded | driver_defect) // RL9
		& ~conflict; // RL10

	// events except address set seen against the registered copy, one cycle after the cause
	always_comb begin
		ev_set = '0;
		// ready resets low, so its first rise after reset is no event
		ev_set[MSB_EV_READY_LOST] = st_reg.ev_armed & st_reg.ready & ~ready_now;
		ev_set[MSB_EV_READY_BACK] = st_reg.ev_armed & ~st_reg.ready & ready_now;
		ev_set[MSB_EV_CONFLICT] = conflict & ~st_reg.conflict;
		ev_set[MSB_EV_ADDR_MODE] = addr_cable_in & ~st_reg.addr_mode;
		ev_set[MSB_EV_ADDR_SET] = tool_addr_valid & addr_cable_in;
	end

	////////////////////////////////////////////////////////////////////////
	// bus handshakes
	assign aw_fire = s_axi_awvalid & st_reg.awready;
	assign w_fire = s_axi_wvalid & st_reg.wready;
	assign ar_fire = s_axi_arvalid & st_reg.arready;
	assign wr_go = (aw_fire | st_reg.aw_have) & (w_fire | st_reg.w_have)
		& (st_reg.wst == MSB_WS_IDLE);
	assign wr_addr = st_reg.aw_have ? st_reg.aw_addr : s_axi_awaddr;
	assign wr_data = st_reg.w_have ? st_reg.w_data : s_axi_wdata;
	assign wr_lane0 = st_reg.w_have ? st_reg.w_lane0 : s_axi_wstrb[0];
	assign ev_clr = ar_fire & (s_axi_araddr == MSB_OFS_IRQ_STAT);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_next = st_reg;
		// write address and data may arrive in either order
		if (aw_fire) begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (w_fire) begin
			st_next.w_have = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_lane0 = s_axi_wstrb[0];
		end
		case (st_reg.wst)
			MSB_WS_IDLE: begin
				if (wr_go) begin
					st_next.wst = MSB_WS_RESP;
					st_next.aw_have = 1'b0;
					st_next.w_have = 1'b0;
					st_next.bresp = MSB_RESP_OKAY;
					case (wr_addr)
						MSB_OFS_CMD: begin
							// the network is cut off while addressing
							if (wr_lane0 && !addr_cable_in) begin
								st_next.cmd = wr_data[MSB_CMD_W-1:0]; // RL2 RL12
							end
						end
						MSB_OFS_IRQ_MASK: begin
							if (wr_lane0) begin
								st_next.irq_mask = wr_data[MSB_EV_W-1:0];
							end
						end
						MSB_OFS_CONFIG: begin
							if (wr_lane0) begin
								st_next.brake_fitted = wr_data[MSB_CFG_BRAKE_FITTED];
							end
						end
						MSB_OFS_STATUS, MSB_OFS_IRQ_STAT, MSB_OFS_SLV_ADDR: begin
							st_next.bresp = MSB_RESP_OKAY; // read-only, write dropped
						end
						default: begin
							st_next.bresp = MSB_RESP_SLVERR;
						end
					endcase
				end
			end
			MSB_WS_RESP: begin
				if (s_axi_bready) begin
					st_next.wst = MSB_WS_IDLE;
				end
			end
			default: begin
				st_next.wst = MSB_WS_IDLE;
			end
		endcase
		// one write in flight: hold both channels off until the response
		st_next.awready = ~st_next.aw_have & (st_next.wst == MSB_WS_IDLE);
		st_next.wready = ~st_next.w_have & (st_next.wst == MSB_WS_IDLE);
		st_next.bvalid = (st_next.wst == MSB_WS_RESP);

		// read channel: data one cycle after the address is taken
		case (st_reg.rst)
			MSB_RS_IDLE: begin
				if (ar_fire) begin
					st_next.rst = MSB_RS_DATA;
					st_next.rdata = '0;
					st_next.rresp = MSB_RESP_OKAY;
					case (s_axi_araddr)
						MSB_OFS_CMD: begin
							st_next.rdata[MSB_CMD_W-1:0] = st_reg.cmd;
						end
						MSB_OFS_STATUS: begin
							st_next.rdata[MSB_ST_READY] = st_reg.ready; // RL6 RL11
							st_next.rdata[MSB_ST_RUNNING] = st_reg.running; // RL13
							st_next.rdata[MSB_ST_SPARE1] = st_reg.spare1; // RL13
							st_next.rdata[MSB_ST_SPARE2] = st_reg.spare2; // RL13
							st_next.rdata[MSB_ST_ADDR_MODE] = st_reg.addr_mode;
							st_next.rdata[MSB_ST_CONFLICT] = st_reg.conflict;
						end
						MSB_OFS_IRQ_STAT: begin
							st_next.rdata[MSB_EV_W-1:0] = flags;
						end
						MSB_OFS_IRQ_MASK: begin
							st_next.rdata[MSB_EV_W-1:0] = st_reg.irq_mask;
						end
						MSB_OFS_CONFIG: begin
							st_next.rdata[MSB_CFG_BRAKE_FITTED] = st_reg.brake_fitted;
						end
						MSB_OFS_SLV_ADDR: begin
							st_next.rdata[MSB_SADDR_W-1:0] = st_reg.slave_addr;
						end
						default: begin
							st_next.rresp = MSB_RESP_SLVERR;
						end
					endcase
				end
			end
			MSB_RS_DATA: begin
				if (s_axi_rready) begin
					st_next.rst = MSB_RS_IDLE;
				end
			end
			default: begin
				st_next.rst = MSB_RS_IDLE;
			end
		endcase
		st_next.arready = (st_next.rst == MSB_RS_IDLE);
		st_next.rvalid = (st_next.rst == MSB_RS_DATA);

		// slave address from the tool; no field wiring condition applies
		if (tool_addr_valid && addr_cable_in) begin
			st_next.slave_addr = tool_addr; // RL1
		end

		// status snapshot in the profile bit order
		st_next.ready = ready_now; // RL6
		st_next.running = contactor_on; // RL13
		st_next.spare1 = spare_field_input_one; // RL13
		st_next.spare2 = spare_field_input_two; // RL13
		st_next.addr_mode = addr_cable_in;
		st_next.conflict = conflict; // RL10
		st_next.fwd_out = fwd_drive; // RL12
		st_next.rev_out = rev_drive; // RL12
		st_next.brake_out = brake_drive; // RL3 RL4
		st_next.net_conn = ~addr_cable_in; // RL2
		// irq lags the flag by one cycle so the pin stays a clean flop
		st_next.irq = |(flags & st_reg.irq_mask);
		st_next.ev_armed = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.wst <= MSB_WS_IDLE;
			st_reg.rst <= MSB_RS_IDLE;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
			st_reg.cmd <= MSB_CMD_RST;
			st_reg.brake_fitted <= MSB_BRAKE_FITTED_RST;
			st_reg.irq_mask <= MSB_MASK_RST;
			st_reg.slave_addr <= MSB_SADDR_RST;
			st_reg.net_conn <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign forward_run_out = st_reg.fwd_out;
	assign reverse_run_out = st_reg.rev_out;
	assign brake_command_output = st_reg.brake_out;
	assign net_connected = st_reg.net_conn;
	assign irq = st_reg.irq;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_both_dirs;
		st_reg.cmd[MSB_CMD_FWD] && st_reg.cmd[MSB_CMD_REV];
	endsequence
	sequence s_no_drive_not_ready;
		!forward_run_out && !reverse_run_out && !st_reg.ready;
	endsequence

	a_dir_conflict_fault: assert property ( // RL10
		s_both_dirs |=> s_no_drive_not_ready)
		else $error("both directions drove or kept ready");
	a_manual_not_ready: assert property ( // RL7
		manual_mode |=> !st_reg.ready && !forward_run_out)
		else $error("ready or drive seen in manual mode");
	a_trip_not_ready: assert property ( // RL8
		protection_tripped |=> !st_reg.ready)
		else $error("ready seen while protection tripped");
	a_defect_not_ready: assert property ( // RL9
		(coil_defect || contacts_welded || driver_defect) |=> !st_reg.ready)
		else $error("ready seen with a device defect");
	a_ready_when_clean: assert property ( // RL6
		!manual_mode && !protection_tripped && !coil_defect && !contacts_welded
		&& !driver_defect && !conflict |=> st_reg.ready)
		else $error("ready low with no cause");
	a_brake_variant_gate: assert property ( // RL3
		!st_reg.brake_fitted |=> !brake_command_output)
		else $error("brake driven on a variant without brake");
	a_brake_own_bit: assert property ( // RL4
		st_reg.brake_fitted && st_reg.cmd[MSB_CMD_BRAKE] |=> brake_command_output)
		else $error("brake held off by motor state");
	a_isolate_link: assert property ( // RL2
		addr_cable_in |=> !net_connected ##0 $stable(st_reg.cmd))
		else $error("network not cut off while addressing");
	a_tool_address: assert property ( // RL1
		tool_addr_valid && addr_cable_in |=> st_reg.slave_addr == $past(tool_addr))
		else $error("tool address not taken");
	a_status_mirror: assert property ( // RL13
		1'b1 |=> st_reg.running == $past(contactor_on)
		&& st_reg.spare1 == $past(spare_field_input_one)
		&& st_reg.spare2 == $past(spare_field_input_two))
		else $error("status bits do not follow field inputs");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid)
		else $error("write response late");
endmodule

// [msb_top_tb.sv]
`timescale 1ns/1ns
module msb_top_tb
	import msb_pkg::*;
;
	localparam int TIMEOUT = 6000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	// fault levels: manual, tripped, coil, welded, driver
	logic [4:0] flt = 5'h00;
	logic [1:0] spare = 2'b00;
	logic addr_cable_in = 1'b0;
	logic tool_addr_valid = 1'b0;
	logic [4:0] tool_addr = 5'h00;
	logic contactor_on, forward_run_out, reverse_run_out, brake_command_output;
	logic net_connected, irq;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] d;
	logic [1:0] r;

	////////////////////////////////////////////////////////////////////////////////
	msb_top u_msb_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .contactor_on(contactor_on), .manual_mode(flt[0]),
		.protection_tripped(flt[1]), .coil_defect(flt[2]), .contacts_welded(flt[3]),
		.driver_defect(flt[4]), .spare_field_input_one(spare[0]),
		.spare_field_input_two(spare[1]), .addr_cable_in(addr_cable_in),
		.tool_addr_valid(tool_addr_valid), .tool_addr(tool_addr),
		.forward_run_out(forward_run_out), .reverse_run_out(reverse_run_out),
		.brake_command_output(brake_command_output), .net_connected(net_connected), .irq(irq));
	msb_plant u_msb_plant (.aclk(aclk), .aresetn(aresetn), .forward_run_out(forward_run_out),
		.reverse_run_out(reverse_run_out), .contactor_on(contactor_on));

	////////////////////////////////////////////////////////////////////////////////
	// clock at 50 ns period
	initial begin
		forever #25 aclk = ~aclk;
	end

	// hang guard, generous against the few hundred cycles the sequence needs
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// bus master: address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
		output logic [1:0] resp);
		bit aw_done;
		bit w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		axw(a, v, 4'hf, r);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		axr(a, d, r);
		chk(d, ev);
		chk({30'h0, r}, {30'h0, er});
	endtask

	// drive levels as {forward, reverse, brake}
	task automatic drv(input logic [2:0] e);
		tick(3);
		chk({29'h0, forward_run_out, reverse_run_out, brake_command_output}, {29'h0, e});
	endtask

	task automatic pulse(input logic [4:0] a);
		@(posedge aclk);
		tool_addr <= a;
		tool_addr_valid <= 1'b1;
		@(posedge aclk);
		tool_addr_valid <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({29'h0, forward_run_out, reverse_run_out, brake_command_output}, 32'h0);
		chk({30'h0, net_connected, irq}, 32'h2);
		rd(MSB_OFS_CMD, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_IRQ_MASK, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_CONFIG, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_SLV_ADDR, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_IRQ_STAT, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_STATUS, 32'h1, MSB_RESP_OKAY);
		rd(8'h18, 32'h0, MSB_RESP_SLVERR);
		wr(8'h18, 32'h1, MSB_RESP_SLVERR);
		axw(MSB_OFS_CONFIG, 32'h1, 4'h0, r);
		rd(MSB_OFS_CONFIG, 32'h0, MSB_RESP_OKAY);
		wr(MSB_OFS_STATUS, 32'h3f, MSB_RESP_OKAY);
		rd(MSB_OFS_STATUS, 32'h1, MSB_RESP_OKAY);
	endtask

	task automatic t_motion();
		wr(MSB_OFS_CMD, 32'h1, MSB_RESP_OKAY);
		drv(3'b100);
		rd(MSB_OFS_STATUS, 32'h3, MSB_RESP_OKAY);
		wr(MSB_OFS_CMD, 32'h2, MSB_RESP_OKAY);
		drv(3'b010);
		rd(MSB_OFS_STATUS, 32'h3, MSB_RESP_OKAY);
		wr(MSB_OFS_CMD, 32'h0, MSB_RESP_OKAY);
		drv(3'b000);
	endtask

	task automatic t_conflict();
		axr(MSB_OFS_IRQ_STAT, d, r);
		wr(MSB_OFS_CMD, 32'h3, MSB_RESP_OKAY);
		drv(3'b000);
		rd(MSB_OFS_STATUS, 32'h20, MSB_RESP_OKAY);
		rd(MSB_OFS_IRQ_STAT, 32'h05, MSB_RESP_OKAY);
		wr(MSB_OFS_CMD, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_STATUS, 32'h1, MSB_RESP_OKAY);
	endtask

	// manual and trip also cut the motor; the defects only report
	task automatic t_faults();
		for (int i = 0; i < 5; i++) begin
			wr(MSB_OFS_CMD, 32'h1, MSB_RESP_OKAY);
			@(posedge aclk);
			flt <= 5'h01 << i;
			drv((i < 2) ? 3'b000 : 3'b100);
			rd(MSB_OFS_STATUS, (i < 2) ? 32'h0 : 32'h2, MSB_RESP_OKAY);
			@(posedge aclk);
			flt <= 5'h00;
			tick(3);
			rd(MSB_OFS_STATUS, 32'h3, MSB_RESP_OKAY);
		end
		wr(MSB_OFS_CMD, 32'h0, MSB_RESP_OKAY);
	endtask

	task automatic t_brake();
		wr(MSB_OFS_CMD, 32'h4, MSB_RESP_OKAY);
		drv(3'b000);
		wr(MSB_OFS_CONFIG, 32'h1, MSB_RESP_OKAY);
		drv(3'b001);
		wr(MSB_OFS_CMD, 32'h5, MSB_RESP_OKAY);
		drv(3'b101);
		wr(MSB_OFS_CMD, 32'h1, MSB_RESP_OKAY);
		drv(3'b100);
		// motor stopped before the brake is left open for good
		wr(MSB_OFS_CMD, 32'h0, MSB_RESP_OKAY);
		rd(MSB_OFS_CONFIG, 32'h1, MSB_RESP_OKAY);
	endtask

	task automatic t_spare();
		@(posedge aclk);
		spare <= 2'b01;
		rd(MSB_OFS_STATUS, 32'h5, MSB_RESP_OKAY);
		@(posedge aclk);
		spare <= 2'b10;
		rd(MSB_OFS_STATUS, 32'h9, MSB_RESP_OKAY);
		@(posedge aclk);
		spare <= 2'b00;
	endtask

	task automatic t_addr();
		axr(MSB_OFS_IRQ_STAT, d, r);
		pulse(5'h0b);
		rd(MSB_OFS_SLV_ADDR, 32'h0, MSB_RESP_OKAY);
		@(posedge aclk);
		addr_cable_in <= 1'b1;
		tick(2);
		chk({31'h0, net_connected}, 32'h0);
		rd(MSB_OFS_STATUS, 32'h11, MSB_RESP_OKAY);
		wr(MSB_OFS_CMD, 32'h1, MSB_RESP_OKAY);
		rd(MSB_OFS_CMD, 32'h0, MSB_RESP_OKAY);
		pulse(5'h13);
		rd(MSB_OFS_SLV_ADDR, 32'h13, MSB_RESP_OKAY);
		rd(MSB_OFS_IRQ_STAT, 32'h18, MSB_RESP_OKAY);
		@(posedge aclk);
		addr_cable_in <= 1'b0;
		tick(2);
		chk({31'h0, net_connected}, 32'h1);
	endtask

	task automatic t_irq();
		wr(MSB_OFS_IRQ_MASK, 32'h1, MSB_RESP_OKAY);
		axr(MSB_OFS_IRQ_STAT, d, r);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		@(posedge aclk);
		flt <= 5'h01;
		tick(4);
		chk({31'h0, irq}, 32'h1);
		rd(MSB_OFS_IRQ_STAT, 32'h01, MSB_RESP_OKAY);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		@(posedge aclk);
		flt <= 5'h00;
		tick(4);
		chk({31'h0, irq}, 32'h0);
		rd(MSB_OFS_IRQ_STAT, 32'h02, MSB_RESP_OKAY);
		rd(MSB_OFS_IRQ_MASK, 32'h01, MSB_RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// reset for twelve cycles, then the scenarios in turn
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		tick(2);
		t_reset();
		t_motion();
		t_conflict();
		t_faults();
		t_brake();
		t_spare();
		t_addr();
		t_irq();
		tally_and_finish();
	end
endmodule
